// ==== logic/motor_ctrl_status_command_regs.sv ====
// Purpose: register slice for telemetry, algorithm commands, speed control
// Assumes: simple synchronous register port, inputs sync to clock
// Notes: command bits are one-cycle pulses to the control core, except the kick, which is held until the core consumes it
//
// Overview of operation
// R1: Telemetry bits 31-16 report supply current, raw/256 gives amperes.
// R2: Telemetry bits 15-0 report input power, raw/64 gives watts.
// R3: A written one at bit 31 of the command register stores shadow to NVM.
// R4: A written one at bit 30 recalls NVM contents to the shadow registers.
// R5: A written one at bit 29 clears all driver and controller faults.
// R6: A written one at bit 28 clears the lock fault retry counters.
// R7: Store is honoured only when bits 27-20 hold the correct unlock key.
// R8: In bus watchdog mode the host periodically writes one to bit 0.
// R9: The core clears the watchdog kick bit on its own after it is set.
// R10: The host leaves unlisted offsets untouched as reserved.
// R11: Control bit 15 picks the speed pin or the register speed value.
// R12: Control bits 30-16 hold the digital speed, percent = value/32767.
// R13: Command bits fire once on a written one; a zero starts nothing.
// R14: Telemetry writes are ignored and it shows the latest measurement.
`timescale 1ns/1ps
module motor_ctrl_status_command_regs
  import motor_regs_pkg::*;
#(
  parameter logic [7:0] unlock_key = motor_regs_pkg::default_unlock_key
)(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // measurements from the control core
  input wire motor_regs_pkg::telemetry_t meas,
  input wire logic kick_consumed,
  // commands to the control core
  output motor_regs_pkg::cmd_pulses_t cmd,
  output logic host_watchdog_kick,
  output logic speed_source_select,
  output logic [14:0] digital_speed_command
);
  import motor_regs_pkg::*;

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  // key compare and speed slice are sized by unlock_key and the speed port, so the
  // package field positions must agree with them
  localparam int key_width = key_msb - key_lsb + 1;
  localparam int speed_width = speed_msb - speed_lsb + 1;
  if (key_width != $bits(unlock_key))
  begin : bad_key_width
    $error("unlock key field width does not match the key");
  end
  if (speed_width != $bits(digital_speed_command))
  begin : bad_speed_width
    $error("speed field width does not match the speed port");
  end

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic cmd_wr;
  wire logic ctl_wr;
  wire logic key_ok;
  wire logic [31:0] read_mux;
  assign cmd_wr = reg_write && (reg_addr == algorithm_command_off);
  assign ctl_wr = reg_write && (reg_addr == device_speed_control_off);
  assign key_ok = reg_wdata[key_msb:key_lsb] == unlock_key; // [R7]
  // telemetry is never stored, so writes to it have no target [R14]
  assign read_mux = (reg_addr == bus_power_telemetry_off) ?
                    {meas.current, meas.power} : reg_reset; // [R1] [R2]

  // ---------------------------------------------------------------
  // command pulses
  // ---------------------------------------------------------------
  cmd_pulses_t cmd_next;
  logic kick_reg;
  logic select_reg;
  logic [14:0] speed_reg;
  always_comb
  begin
    cmd_next = '0;
    if (cmd_wr)
    begin
      cmd_next.store = reg_wdata[store_bit] && key_ok; // [R3] [R7] [R13]
      cmd_next.recall = reg_wdata[recall_bit]; // [R4] [R13]
      cmd_next.fault_clear = reg_wdata[fault_clear_bit]; // [R5] [R13]
      cmd_next.retry_clear = reg_wdata[retry_clear_bit]; // [R6] [R13]
      cmd_next.kick_set = reg_wdata[kick_bit]; // [R13]
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd <= '0;
      reg_rdata <= reg_reset;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      cmd <= cmd_next;
      reg_rvalid <= reg_read;
      reg_rdata <= reg_read ? read_mux : reg_reset;
    end
  end

  // ---------------------------------------------------------------
  // watchdog kick: set by host, cleared by core, set wins
  // a kick landing with the core's clear must not be lost
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      kick_reg <= 1'b0;
    else if (cmd_next.kick_set)
      kick_reg <= 1'b1;
    else if (kick_consumed)
      kick_reg <= 1'b0; // [R9]
  end
  assign host_watchdog_kick = kick_reg;

  // ---------------------------------------------------------------
  // speed control register
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      select_reg <= 1'b0;
      speed_reg <= '0;
    end
    else if (ctl_wr)
    begin
      select_reg <= reg_wdata[select_bit]; // [R11]
      speed_reg <= reg_wdata[speed_msb:speed_lsb]; // [R12]
    end
  end
  assign speed_source_select = select_reg;
  assign digital_speed_command = speed_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_locked_store;
    cmd_wr && reg_wdata[store_bit] && !key_ok;
  endsequence
  sequence s_keyed_store;
    cmd_wr && reg_wdata[store_bit] && key_ok;
  endsequence
  sequence s_no_command;
    cmd_wr && (reg_wdata[store_bit:retry_clear_bit] == '0)
    && !reg_wdata[kick_bit];
  endsequence
  sequence s_kick_write;
    cmd_wr && reg_wdata[kick_bit];
  endsequence
  sequence s_kick_waiting;
    kick_reg && !kick_consumed && !cmd_next.kick_set;
  endsequence
  sequence s_telemetry_read;
    reg_read && (reg_addr == bus_power_telemetry_off);
  endsequence

  // ---------------------------------------------------------------
  // command pulse checks
  // ---------------------------------------------------------------
  chk_store_needs_key: assert property ( // [R7]
    @(posedge clock) disable iff (!resetn)
    s_locked_store |=> !cmd.store)
    else $error("store without key");
  chk_store_fires: assert property ( // [R3]
    @(posedge clock) disable iff (!resetn)
    s_keyed_store |=> cmd.store)
    else $error("keyed store lost");
  chk_recall_fires: assert property ( // [R4]
    @(posedge clock) disable iff (!resetn)
    cmd_wr && reg_wdata[recall_bit] |=> cmd.recall)
    else $error("recall lost");
  chk_fault_clear: assert property ( // [R5]
    @(posedge clock) disable iff (!resetn)
    cmd_wr && reg_wdata[fault_clear_bit] |=> cmd.fault_clear)
    else $error("fault clear lost");
  chk_retry_clear: assert property ( // [R6]
    @(posedge clock) disable iff (!resetn)
    cmd_wr && reg_wdata[retry_clear_bit] |=> cmd.retry_clear)
    else $error("retry clear lost");
  chk_pulse_single: assert property ( // [R13]
    @(posedge clock) disable iff (!resetn)
    !cmd_wr |=> cmd == '0)
    else $error("command without write");
  chk_zero_no_action: assert property ( // [R13]
    @(posedge clock) disable iff (!resetn)
    s_no_command |=> cmd == '0)
    else $error("zero write started a command");

  // ---------------------------------------------------------------
  // kick flag checks
  // ---------------------------------------------------------------
  chk_kick_autoclear: assert property ( // [R9]
    @(posedge clock) disable iff (!resetn)
    kick_reg && kick_consumed && !cmd_next.kick_set |=> !kick_reg)
    else $error("kick not cleared");
  chk_kick_set_wins: assert property ( // [R9]
    @(posedge clock) disable iff (!resetn)
    s_kick_write |=> host_watchdog_kick)
    else $error("kick write lost");
  chk_kick_holds: assert property ( // [R9]
    @(posedge clock) disable iff (!resetn)
    s_kick_waiting |=> host_watchdog_kick)
    else $error("kick dropped before consumed");

  // ---------------------------------------------------------------
  // read port and speed register checks
  // ---------------------------------------------------------------
  chk_telemetry_read: assert property ( // [R1] [R2] [R14]
    @(posedge clock) disable iff (!resetn)
    s_telemetry_read |=> reg_rvalid
    && reg_rdata == $past({meas.current, meas.power}))
    else $error("telemetry read wrong");
  chk_speed_load: assert property ( // [R11] [R12]
    @(posedge clock) disable iff (!resetn)
    ctl_wr |=> digital_speed_command == $past(reg_wdata[speed_msb:speed_lsb])
    && speed_source_select == $past(reg_wdata[select_bit]))
    else $error("speed control not loaded");
  chk_speed_holds: assert property ( // [R11] [R12]
    @(posedge clock) disable iff (!resetn)
    !ctl_wr |=> $stable(digital_speed_command)
    && $stable(speed_source_select))
    else $error("speed control changed without write");
endmodule : motor_ctrl_status_command_regs

// ==== pkg/motor_regs_pkg.sv ====
// Purpose: constants and carriers for the command/status register slice
// Assumes: 32-bit register words, byte offsets as printed
// Notes: key value is arbitrary, module parameter overrides it
package motor_regs_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] algorithm_command_off = 12'h0e6;
  localparam logic [11:0] device_speed_control_off = 12'h0e8;
  localparam logic [11:0] bus_power_telemetry_off = 12'h0ec;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int store_bit = 31;
  localparam int recall_bit = 30;
  localparam int fault_clear_bit = 29;
  localparam int retry_clear_bit = 28;
  localparam int key_lsb = 20;
  localparam int key_msb = 27;
  localparam int kick_bit = 0;
  localparam int select_bit = 15;
  localparam int speed_lsb = 16;
  localparam int speed_msb = 30;
  localparam int current_lsb = 16;
  localparam int power_lsb = 0;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] reg_reset = 32'h0000_0000;
  localparam logic [7:0] default_unlock_key = 8'h5a;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic store;
    logic recall;
    logic fault_clear;
    logic retry_clear;
    logic kick_set;
  } cmd_pulses_t;

  typedef struct packed {
    logic [15:0] current;
    logic [15:0] power;
  } telemetry_t;
endpackage : motor_regs_pkg

// ==== tb/core_model.sv ====
// Purpose: control core stand-in for telemetry and kick handling
// Assumes: bench chooses the measured values
// Notes: a kick is consumed only after a fixed lag
`timescale 1ns/1ps
module core_model
  import motor_regs_pkg::*;
#(
  parameter int lag = 3
)(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // measurement sources and kick flag
  input wire logic [15:0] cur_val,
  input wire logic [15:0] pow_val,
  input wire logic host_watchdog_kick,
  // to the register slice
  output motor_regs_pkg::telemetry_t meas,
  output logic kick_consumed
);
  int cnt;
  assign meas = '{current: cur_val, power: pow_val};
  always @(negedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= 0;
      kick_consumed <= 1'b0;
    end
    else
    begin
      // restart the lag after each consume so a re-set kick clears again
      cnt <= (host_watchdog_kick && cnt != lag) ? cnt + 1 : 0;
      kick_consumed <= host_watchdog_kick && cnt == lag;
    end
  end
endmodule : core_model

// ==== tb/motor_ctrl_status_command_regs_bench.sv ====
// Purpose: self-checking bench for the command/status slice
// Assumes: default unlock key, inputs change at falling edges
// Notes: commands run from a table, kick/speed/reads by hand
`timescale 1ns/1ps
module motor_ctrl_status_command_regs_bench;
  import motor_regs_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [4:0] c;} row_t;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic [15:0] cur_val = 16'h1234;
  logic [15:0] pow_val = 16'h0abc;
  logic [31:0] reg_rdata;
  logic reg_rvalid, kick_consumed, host_watchdog_kick, speed_source_select;
  logic [14:0] digital_speed_command;
  logic [31:0] speed_seen;
  telemetry_t meas;
  cmd_pulses_t cmd;
  int n_errors = 0;
  int cmp_count = 0;
  // only mapped offsets are written, reserved ones stay untouched
  row_t rows [9] = '{'{12'h0e6, 32'h85a0_0000, 5'h10},
    '{12'h0e6, 32'h80f0_0000, 5'h00}, '{12'h0e6, 32'h4000_0000, 5'h08},
    '{12'h0e6, 32'h2000_0000, 5'h04}, '{12'h0e6, 32'h1000_0000, 5'h02},
    '{12'h0e6, 32'h0000_0001, 5'h01}, '{12'h0e6, 32'h0000_0000, 5'h00},
    '{12'h0ec, 32'hffff_ffff, 5'h00}, '{12'h0e8, 32'h85a0_0001, 5'h00}};
  always #10 clock = ~clock;
  assign speed_seen = {16'h0000, digital_speed_command, speed_source_select};
  motor_ctrl_status_command_regs dut_u (.clock(clock), .resetn(resetn),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .meas(meas), .kick_consumed(kick_consumed), .cmd(cmd),
    .host_watchdog_kick(host_watchdog_kick),
    .speed_source_select(speed_source_select),
    .digital_speed_command(digital_speed_command));
  core_model core_u (.clock(clock), .resetn(resetn), .cur_val(cur_val),
    .pow_val(pow_val), .host_watchdog_kick(host_watchdog_kick),
    .meas(meas), .kick_consumed(kick_consumed));
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // strobe held over exactly one rising edge
  task automatic wr(logic [11:0] a, logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
  endtask : wr
  task automatic rd(logic [11:0] a, logic [31:0] e);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    chk("rvalid", 32'h1, 32'(reg_rvalid));
    chk("rdata", e, reg_rdata);
  endtask : rd
  task automatic end_sim();
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  initial
  begin
    #200us;
    n_errors++;
    end_sim();
  end
  initial
  begin
    repeat (12) @(negedge clock);
    resetn = 1'b1;
    chk("cmd", 32'h0, 32'({cmd}));
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      chk("cmd", 32'(rows[i].c), 32'({cmd}));
      @(negedge clock);
      chk("cmd idle", 32'h0, 32'({cmd}));
    end
    repeat (8) @(negedge clock);
    wr(12'h0e6, 32'h0000_0001);
    chk("kick", 32'h1, 32'(host_watchdog_kick));
    repeat (6) @(negedge clock);
    chk("kick", 32'h0, 32'(host_watchdog_kick));
    // second kick lands in the cycle the core consumes the first
    wr(12'h0e6, 32'h0000_0001);
    repeat (3) @(negedge clock);
    wr(12'h0e6, 32'h0000_0001);
    chk("kick kept", 32'h1, 32'(host_watchdog_kick));
    repeat (6) @(negedge clock);
    chk("kick", 32'h0, 32'(host_watchdog_kick));
    wr(12'h0e8, 32'h7fff_8000);
    chk("speed", 32'hffff, speed_seen);
    @(negedge clock);
    wr(12'h0e8, 32'h0001_0000);
    chk("speed", 32'h0002, speed_seen);
    @(negedge clock);
    rd(12'h0ec, 32'h1234_0abc);
    @(negedge clock);
    cur_val = 16'hbeef;
    pow_val = 16'h0040;
    rd(12'h0ec, 32'hbeef_0040);
    @(negedge clock);
    rd(12'h0e6, 32'h0);
    resetn = 1'b0;
    @(negedge clock);
    chk("speed", 32'h0, speed_seen);
    resetn = 1'b1;
    @(negedge clock);
    wr(12'h0e8, 32'h0001_8000);
    chk("speed", 32'h0003, speed_seen);
    end_sim();
  end
endmodule : motor_ctrl_status_command_regs_bench
